/* File: src/mcsr_consts.svh */
`ifndef MCSR_CONSTS_SVH
`define MCSR_CONSTS_SVH
// ***********************************************
// register word addresses
// ***********************************************
`define MCSR_A_PASSCODE 16'h0527
`define MCSR_A_PROTECT 16'h0529
`define MCSR_A_ESCALE 16'h052E
`define MCSR_A_SUBSEC 16'h052F
`define MCSR_A_SUBTOT 16'h0530
`define MCSR_A_DRESTART 16'h0531
`define MCSR_A_FAUTO 16'h0532
`define MCSR_A_FCHAN 16'h0533
`define MCSR_A_NV_BASE 16'h0540
`define MCSR_A_NV_LAST 16'h055F
`define MCSR_A_NODE 16'h0600
`define MCSR_A_BITRATE 16'h0601
`define MCSR_A_CHECK 16'h0602
`define MCSR_A_STOPS 16'h0603
`define MCSR_A_RWAIT 16'h0604
`define MCSR_A_APPLY 16'h0605
`define MCSR_A_SPARE_A 16'h0606
`define MCSR_A_SPARE_B 16'h0607
`define MCSR_A_RUNST 16'h0608
`define MCSR_A_RB_NORM 16'h0609
`define MCSR_A_RB_LOAD 16'h060A
// ***********************************************
// reset values and keys
// ***********************************************
`define MCSR_RST_ESCALE 16'h0064
`define MCSR_RST_SUBSEC 16'h003C
`define MCSR_RST_SUBTOT 16'h0001
`define MCSR_RST_NODE 16'h000F
`define MCSR_RST_BITRATE 16'h2580
`define MCSR_RST_CHECK 16'h0000
`define MCSR_RST_STOPS 16'h0001
`define MCSR_RST_RWAIT 16'h0000
`define MCSR_KEY_NORM 16'hAA55
`define MCSR_KEY_LOAD 16'hB001
`define MCSR_MODE_RUN 16'h0001
`define MCSR_MODE_LOADER 16'h0002
`define MCSR_NODE_MAX 16'h00F7
`define MCSR_SWITCH_REG 4'hF
`define MCSR_SUBTOT_MAX 16'h003C
`define MCSR_PROT_CHANGE 16'h0002
`define MCSR_NV_LIMIT 16'h2710
`define MCSR_CLK_HZ 25000000
`define MCSR_CONFIRM_S 180
`define MCSR_CONFIRM_CYC (64'(`MCSR_CONFIRM_S) * `MCSR_CLK_HZ)
`endif

/* File: src/mcsr_pkg.sv */
package mcsr_pkg;
    // register access request from the message layer
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mcsr_req_t;
    // active serial line settings
    typedef struct packed {
        logic [7:0] node;
        logic [15:0] bit_rate;
        logic [15:0] check_bit;
        logic [15:0] end_bits;
        logic [15:0] wait_ms;
    } mcsr_line_t;
    // commit confirmation states
    typedef enum logic [1:0] {
        MCSR_CF_IDLE = 2'b01,
        MCSR_CF_WAIT = 2'b10
    } mcsr_cf_t;
endpackage : mcsr_pkg

/* File: src/mcsr_demand.sv */
`timescale 1ns/1ps
`include "mcsr_consts.svh"
// ***********************************************
// sliding window demand averager
// ***********************************************
module mcsr_demand #(
    parameter int SEC_CYCLES = 25000000,
    parameter int SLOTS = 60
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic restart,
    input wire logic [15:0] sub_seconds,
    input wire logic [15:0] sub_total,
    input wire logic signed [31:0] power_in,
    // result
    output logic signed [31:0] demand_out,
    output logic demand_upd
);
    logic [31:0] tick_q;
    logic [15:0] sec_q;
    logic [5:0] slot_q;
    logic [5:0] filled_q;
    logic signed [47:0] acc_q;
    logic signed [47:0] win_q [SLOTS];
    logic signed [47:0] sum_c;
    logic signed [47:0] avg_c;
    logic sub_end;
    // sum of stored sub-interval energies
    always_comb begin
        sum_c = acc_q + 48'(power_in);
        for (int i = 0; i < SLOTS; i++) begin
            if (i != int'(slot_q) && i < int'(sub_total)) begin
                sum_c = sum_c + win_q[i];
            end
        end
        avg_c = sum_c / $signed({32'h0, sub_seconds}) / $signed({32'h0, sub_total});
    end
    assign sub_end = (tick_q == 32'(SEC_CYCLES - 1)) && (sec_q + 16'h0001 >= sub_seconds);
    // second and sub-interval timing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= 32'h0;
            sec_q <= 16'h0;
            slot_q <= 6'h0;
            acc_q <= 48'sh0;
            filled_q <= 6'h0;
        end else if (restart) begin
            tick_q <= 32'h0;
            sec_q <= 16'h0;
            slot_q <= 6'h0;
            acc_q <= 48'sh0;
            filled_q <= 6'h0;
        end else if (tick_q == 32'(SEC_CYCLES - 1)) begin
            tick_q <= 32'h0;
            acc_q <= sub_end ? 48'sh0 : acc_q + 48'(power_in);
            sec_q <= sub_end ? 16'h0 : sec_q + 16'h0001;
            if (sub_end) begin
                slot_q <= (slot_q + 6'h01 >= sub_total[5:0]) ? 6'h0 : slot_q + 6'h01;
                if (filled_q < sub_total[5:0]) begin
                    filled_q <= filled_q + 6'h01;
                end
            end
        end else begin
            tick_q <= tick_q + 32'h1;
        end
    end
    // window store, one slot per sub-interval
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < SLOTS; i++) begin
                win_q[i] <= 48'sh0;
            end
        end else if (sub_end && !restart) begin
            win_q[slot_q] <= acc_q + 48'(power_in);
        end
    end
    // output refreshed each sub-interval end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            demand_out <= 32'sh0;
            demand_upd <= 1'b0;
        end else begin
            demand_upd <= sub_end && !restart;
            if (sub_end && !restart) begin
                demand_out <= avg_c[31:0];
            end
        end
    end
endmodule : mcsr_demand

/* File: src/mcsr_regs.sv */
`timescale 1ns/1ps
`include "mcsr_consts.svh"
// How it works
// - passcode zero then protection write two removes protection; passcode reads zero after reset, one after any passcode write
// - phase compensation is lag in hundredths of a degree
// - integer energy is raw energy over scale register, default 100
// - integer energy is signed 32-bit, clamped
// - float energy passes unscaled
// - sub-interval length accepts one to 65535 seconds
// - sub-interval count one to sixty
// - demand updates each sub-interval end with window average
// - length or count write, or restart word one, restarts demand
// - auto mode picks a channel above 5 V, reselects, reports zero otherwise
// - active channel code: 0 A, 1 B, 2 C
// - force: auto select zero, then channel code
// - thirty-two scratch words, cleared to zero by reset
// - after ten thousand scratch writes the unit may turn read-only
// - switch fifteen uses node register, default fifteen; else switch
// - node register above 247 is never used as the address
// - line settings apply on commit of one, kept on valid query
// - the two spare words always read zero
// - run state reads one normally, two in loader
// - key AA55 on normal reboot word restarts firmware; reads zero
// - key B001 on loader reboot word restarts loader; reads zero
// - no valid query in three minutes restores old settings; reset restores defaults
module mcsr_regs #(
    parameter longint CONFIRM_CYCLES = `MCSR_CONFIRM_CYC,
    parameter int SEC_CYCLES = `MCSR_CLK_HZ,
    parameter int NV_WORDS = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register access
    input wire mcsr_pkg::mcsr_req_t req,
    output logic [15:0] rdata,
    // line events and straps
    input wire logic query_ok,
    input wire logic [3:0] addr_switch,
    input wire logic in_loader,
    // measurement side
    input wire logic signed [47:0] energy_raw,
    input wire logic signed [31:0] power_in,
    input wire logic [2:0] volt_ok,
    // outputs
    output logic signed [31:0] energy_int,
    output logic signed [47:0] energy_float_src,
    output logic signed [31:0] demand_power,
    output logic [1:0] freq_chan,
    output logic freq_valid,
    output logic [15:0] phase_comp,
    output mcsr_pkg::mcsr_line_t line_cfg,
    output logic reboot_pulse,
    output logic reboot_to_loader,
    output logic nv_read_only
);
    import mcsr_pkg::*;
    localparam mcsr_line_t LINE_RST = '{8'(`MCSR_RST_NODE), `MCSR_RST_BITRATE, `MCSR_RST_CHECK,
        `MCSR_RST_STOPS, `MCSR_RST_RWAIT};
    // ***********************************************
    // decode helpers
    // ***********************************************
    function automatic logic hit(input mcsr_req_t r, input logic [15:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit
    logic wr_ok;
    logic pass_zero_q, prot_off_q;
    logic [15:0] pass_rd_q, phase_q, escale_q, subsec_q, subtot_q, fauto_q, fchan_q;
    logic [15:0] nv_q [NV_WORDS];
    logic [15:0] nv_cnt_q;
    mcsr_line_t staged_q, prev_q, act_q;
    mcsr_cf_t cf_q;
    logic [32:0] cf_cnt_q;
    logic demand_rst;
    logic signed [47:0] quot_c;
    assign wr_ok = req.wr;
    // ***********************************************
    // protection removal
    // ***********************************************
    // only removal is built; locking is not
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pass_zero_q <= 1'b0;
            prot_off_q <= 1'b0;
            pass_rd_q <= 16'h0;
        end else if (hit(req, `MCSR_A_PASSCODE) || hit(req, `MCSR_A_PASSCODE + 16'h1)) begin
            pass_zero_q <= (req.wdata == 16'h0);
            pass_rd_q <= 16'h0001;
        end else if (hit(req, `MCSR_A_PROTECT)) begin
            if (req.wdata == `MCSR_PROT_CHANGE && pass_zero_q) begin
                prot_off_q <= 1'b1;
            end
        end
    end
    // ***********************************************
    // measurement configuration
    // ***********************************************
    // phase, scale and demand words; bad values refused
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 16'h0;
            escale_q <= `MCSR_RST_ESCALE;
            subsec_q <= `MCSR_RST_SUBSEC;
            subtot_q <= `MCSR_RST_SUBTOT;
        end else begin
            if (hit(req, `MCSR_A_PASSCODE - 16'h1)) begin
                phase_q <= req.wdata;
            end
            if (hit(req, `MCSR_A_ESCALE) && req.wdata != 16'h0) begin
                escale_q <= req.wdata;
            end
            if (hit(req, `MCSR_A_SUBSEC) && req.wdata != 16'h0) begin
                subsec_q <= req.wdata;
            end
            if (hit(req, `MCSR_A_SUBTOT) && req.wdata != 16'h0 && req.wdata <= `MCSR_SUBTOT_MAX) begin
                subtot_q <= req.wdata;
            end
        end
    end
    // any length or count write, or restart word of one
    assign demand_rst = hit(req, `MCSR_A_SUBSEC) || hit(req, `MCSR_A_SUBTOT)
        || (hit(req, `MCSR_A_DRESTART) && req.wdata == 16'h0001);
    mcsr_demand #(
        .SEC_CYCLES(SEC_CYCLES),
        .SLOTS(60)
    ) u_demand (
        .clk(clk),
        .reset_n(reset_n),
        .restart(demand_rst),
        .sub_seconds(subsec_q),
        .sub_total(subtot_q),
        .power_in(power_in),
        .demand_out(demand_power),
        .demand_upd()
    );
    // ***********************************************
    // energy scaling
    // ***********************************************
    // combinational divide: slow, but fine for a register view
    assign quot_c = energy_raw / $signed({32'h0, escale_q});
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            energy_int <= 32'sh0;
            energy_float_src <= 48'sh0;
            phase_comp <= 16'h0;
        end else begin
            if (quot_c > 48'sh0000_7FFF_FFFF) begin
                energy_int <= 32'sh7FFF_FFFF;
            end else if (quot_c < -48'sh0000_8000_0000) begin
                energy_int <= 32'sh8000_0000;
            end else begin
                energy_int <= quot_c[31:0];
            end
            energy_float_src <= energy_raw;
            phase_comp <= phase_q;
        end
    end
    // ***********************************************
    // frequency channel selection
    // ***********************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fauto_q <= 16'h0001;
            fchan_q <= 16'h0;
            freq_valid <= 1'b0;
        end else if (hit(req, `MCSR_A_FAUTO)) begin
            fauto_q <= req.wdata;
        end else if (fauto_q == 16'h0) begin
            if (hit(req, `MCSR_A_FCHAN) && req.wdata <= 16'h0002) begin
                fchan_q <= req.wdata;
            end
            freq_valid <= volt_ok[fchan_q[1:0]];
        end else if (!volt_ok[fchan_q[1:0]] || fchan_q > 16'h0002) begin
            // reselect lowest qualifying channel
            freq_valid <= |volt_ok;
            fchan_q <= volt_ok[0] ? 16'h0 : volt_ok[1] ? 16'h1 : volt_ok[2] ? 16'h2 : fchan_q;
        end else begin
            freq_valid <= 1'b1;
        end
    end
    assign freq_chan = fchan_q[1:0];
    // ***********************************************
    // scratch words and endurance guard
    // ***********************************************
    generate
        for (genvar g = 0; g < NV_WORDS; g++) begin : g_nv
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    nv_q[g] <= 16'h0;
                end else if (hit(req, `MCSR_A_NV_BASE + 16'(g)) && !nv_read_only) begin
                    nv_q[g] <= req.wdata;
                end
            end
        end
    endgenerate
    // scratch write counter; read-only past the limit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nv_cnt_q <= 16'h0;
            nv_read_only <= 1'b0;
        end else if (wr_ok && req.addr >= `MCSR_A_NV_BASE && req.addr <= `MCSR_A_NV_LAST && !nv_read_only) begin
            nv_cnt_q <= nv_cnt_q + 16'h1;
            nv_read_only <= (nv_cnt_q + 16'h1 >= `MCSR_NV_LIMIT);
        end
    end
    // ***********************************************
    // line settings, commit and confirmation
    // ***********************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            staged_q <= LINE_RST;
        end else if (wr_ok) begin
            if (hit(req, `MCSR_A_NODE) && req.wdata != 16'h0 && req.wdata <= `MCSR_NODE_MAX) begin
                staged_q.node <= req.wdata[7:0];
            end else if (hit(req, `MCSR_A_BITRATE)) begin
                staged_q.bit_rate <= req.wdata;
            end else if (hit(req, `MCSR_A_CHECK)) begin
                staged_q.check_bit <= req.wdata;
            end else if (hit(req, `MCSR_A_STOPS)) begin
                staged_q.end_bits <= req.wdata;
            end else if (hit(req, `MCSR_A_RWAIT)) begin
                staged_q.wait_ms <= req.wdata;
            end
        end
    end
    // reset counts as a reboot: defaults return
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            act_q <= LINE_RST;
            prev_q <= LINE_RST;
            cf_q <= MCSR_CF_IDLE;
            cf_cnt_q <= 33'h0;
        end else begin
            case (cf_q)
                MCSR_CF_IDLE: begin
                    if (hit(req, `MCSR_A_APPLY) && req.wdata == 16'h0001) begin
                        prev_q <= act_q;
                        act_q <= staged_q;
                        cf_cnt_q <= 33'h0;
                        cf_q <= MCSR_CF_WAIT;
                    end
                end
                MCSR_CF_WAIT: begin
                    if (query_ok) begin
                        cf_q <= MCSR_CF_IDLE;
                    end else if (cf_cnt_q >= 33'(CONFIRM_CYCLES - 1)) begin
                        act_q <= prev_q;
                        cf_q <= MCSR_CF_IDLE;
                    end else begin
                        cf_cnt_q <= cf_cnt_q + 33'h1;
                    end
                end
                default: begin
                    cf_q <= MCSR_CF_IDLE;
                end
            endcase
        end
    end
    // switch fifteen hands the address to the register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_cfg <= LINE_RST;
        end else begin
            line_cfg <= act_q;
            if (addr_switch != `MCSR_SWITCH_REG) begin
                line_cfg.node <= {4'h0, addr_switch};
            end
        end
    end
    // ***********************************************
    // reboot keys
    // ***********************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reboot_pulse <= 1'b0;
            reboot_to_loader <= 1'b0;
        end else begin
            reboot_pulse <= (hit(req, `MCSR_A_RB_NORM) && req.wdata == `MCSR_KEY_NORM)
                || (hit(req, `MCSR_A_RB_LOAD) && req.wdata == `MCSR_KEY_LOAD);
            if (hit(req, `MCSR_A_RB_NORM) && req.wdata == `MCSR_KEY_NORM) begin
                reboot_to_loader <= 1'b0;
            end else if (hit(req, `MCSR_A_RB_LOAD) && req.wdata == `MCSR_KEY_LOAD) begin
                reboot_to_loader <= 1'b1;
            end
        end
    end
    // ***********************************************
    // read mux
    // ***********************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 16'h0;
        end else if (!req.rd) begin
            rdata <= 16'h0;
        end else if (req.addr == `MCSR_A_PASSCODE || req.addr == `MCSR_A_PASSCODE + 16'h1) begin
            rdata <= pass_rd_q;
        end else if (req.addr == `MCSR_A_PROTECT) begin
            rdata <= prot_off_q ? `MCSR_PROT_CHANGE : 16'h0;
        end else if (req.addr == `MCSR_A_PASSCODE - 16'h1) begin
            rdata <= phase_q;
        end else if (req.addr == `MCSR_A_ESCALE) begin
            rdata <= escale_q;
        end else if (req.addr == `MCSR_A_SUBSEC) begin
            rdata <= subsec_q;
        end else if (req.addr == `MCSR_A_SUBTOT) begin
            rdata <= subtot_q;
        end else if (req.addr == `MCSR_A_FAUTO) begin
            rdata <= fauto_q;
        end else if (req.addr == `MCSR_A_FCHAN) begin
            rdata <= fchan_q;
        end else if (req.addr >= `MCSR_A_NV_BASE && req.addr <= `MCSR_A_NV_LAST) begin
            rdata <= nv_q[req.addr[4:0]];
        end else if (req.addr == `MCSR_A_NODE) begin
            rdata <= {8'h0, staged_q.node};
        end else if (req.addr == `MCSR_A_BITRATE) begin
            rdata <= staged_q.bit_rate;
        end else if (req.addr == `MCSR_A_CHECK) begin
            rdata <= staged_q.check_bit;
        end else if (req.addr == `MCSR_A_STOPS) begin
            rdata <= staged_q.end_bits;
        end else if (req.addr == `MCSR_A_RWAIT) begin
            rdata <= staged_q.wait_ms;
        end else if (req.addr == `MCSR_A_RUNST) begin
            rdata <= in_loader ? `MCSR_MODE_LOADER : `MCSR_MODE_RUN;
        end else begin
            rdata <= 16'h0;
        end
    end
endmodule : mcsr_regs

/* File: test/mcsr_regs_asserts.sv */
`timescale 1ns/1ps
`include "mcsr_consts.svh"
// ****
// register bank checker
// ****
module mcsr_regs_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // watched ports
    input wire mcsr_pkg::mcsr_req_t req,
    input wire logic [15:0] rdata,
    input wire logic [3:0] addr_switch,
    input wire logic in_loader,
    input wire logic signed [47:0] energy_raw,
    input wire logic signed [47:0] energy_float_src,
    input wire mcsr_pkg::mcsr_line_t line_cfg,
    input wire logic reboot_pulse,
    input wire logic reboot_to_loader
);
    import mcsr_pkg::*;
    logic rb_n, rb_l, rd_zero;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // decoded requests
    assign rb_n = req.wr && req.addr == `MCSR_A_RB_NORM;
    assign rb_l = req.wr && req.addr == `MCSR_A_RB_LOAD;
    assign rd_zero = req.rd && req.addr inside {`MCSR_A_SPARE_A, `MCSR_A_SPARE_B, `MCSR_A_RB_NORM, `MCSR_A_RB_LOAD};
    property p_key_norm; rb_n && req.wdata == `MCSR_KEY_NORM |=> reboot_pulse && !reboot_to_loader; endproperty
    a_key_norm: assert property (p_key_norm) else $error("no firmware reboot");
    property p_key_load; rb_l && req.wdata == `MCSR_KEY_LOAD |=> reboot_pulse && reboot_to_loader; endproperty
    a_key_load: assert property (p_key_load) else $error("no loader reboot");
    property p_key_bad; (rb_n && req.wdata != `MCSR_KEY_NORM) || (rb_l && req.wdata != `MCSR_KEY_LOAD) |=> !reboot_pulse; endproperty
    a_key_bad: assert property (p_key_bad) else $error("wrong key caused a reboot");
    property p_pulse; reboot_pulse && !rb_n && !rb_l |=> !reboot_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("reboot pulse too long");
    property p_rd_zero; rd_zero |=> rdata == 16'h0000; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("zero word read nonzero");
    property p_mode; req.rd && req.addr == `MCSR_A_RUNST |=> rdata == ($past(in_loader) ? 16'h0002 : 16'h0001); endproperty
    a_mode: assert property (p_mode) else $error("run state read wrong");
    property p_idle; !$past(req.rd) |-> rdata == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data without a read");
    property p_node_max; line_cfg.node <= 8'hF7; endproperty
    a_node_max: assert property (p_node_max) else $error("node above 247 in use");
    property p_switch; $stable(addr_switch) && addr_switch != `MCSR_SWITCH_REG |=> line_cfg.node == {4'h0, $past(addr_switch)}; endproperty
    a_switch: assert property (p_switch) else $error("switch value not used as node");
    property p_float; $past(reset_n) |-> energy_float_src == $past(energy_raw); endproperty
    a_float: assert property (p_float) else $error("float energy not a raw copy");
endmodule : mcsr_regs_asserts
bind mcsr_regs mcsr_regs_asserts u_chk (.*);

/* File: test/mcsr_host.sv */
`timescale 1ns/1ps
`include "mcsr_consts.svh"
// ****
// bus master stand-in
// ****
module mcsr_host (
    // clock
    input wire logic clk,
    // register access
    output mcsr_pkg::mcsr_req_t req,
    input wire logic [15:0] rdata
);
    import mcsr_pkg::*;
    int nv_writes = 0;
    // idle at time zero
    initial req = '0;
    // one strobe edge, then scrambled lines
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] v, output logic [15:0] q);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: v};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
        @(negedge clk);
        q = rdata;
    endtask : xfer
    // no spare writes; scratch writes capped for flash wear
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        logic [15:0] q;
        if (a inside {`MCSR_A_SPARE_A, `MCSR_A_SPARE_B}) return;
        if (a >= `MCSR_A_NV_BASE && a <= `MCSR_A_NV_LAST && nv_writes++ >= 9999) return;
        xfer(1'b1, a, v, q);
    endtask : wr
endmodule : mcsr_host

/* File: test/meter_config_system_registers_tb.sv */
`timescale 1ns/1ps
// ****
// register bank bench
// ****
module meter_config_system_registers_tb;
    import mcsr_pkg::*;
    logic clk, reset_n, query_ok, in_loader, freq_valid, reboot_pulse, reboot_to_loader, nv_read_only;
    logic [3:0] addr_switch;
    logic [2:0] volt_ok;
    logic [1:0] freq_chan;
    logic signed [47:0] energy_raw, energy_float_src;
    logic signed [31:0] power_in, energy_int, demand_power;
    logic [15:0] rdata, phase_comp, d;
    logic [15:0] lf = 16'h002D;
    mcsr_req_t req;
    mcsr_line_t line_cfg;
    int n_mismatch = 0;
    int samples_checked = 0;
    int mdl [int];
    int ra [12] = '{16'h052E, 16'h052F, 16'h0530, 16'h0600, 16'h0601, 16'h0602, 16'h0603, 16'h0604, 16'h0606,
        16'h0607, 16'h0609, 16'h060A};
    int rv [12] = '{100, 60, 1, 15, 16'h2580, 0, 1, 0, 0, 0, 0, 0};
    int wa [10] = '{16'h052E, 16'h052F, 16'h052F, 16'h0530, 16'h0530, 16'h0530, 16'h0600, 16'h0600, 16'h0600, 16'h0529};
    int wv [10] = '{0, 0, 16'hFFFF, 0, 61, 60, 0, 248, 247, 2};
    mcsr_regs #(.CONFIRM_CYCLES(200), .SEC_CYCLES(4)) u_dut (.clk, .reset_n, .req, .rdata, .query_ok, .addr_switch,
        .in_loader, .energy_raw, .power_in, .volt_ok, .energy_int, .energy_float_src, .demand_power, .freq_chan,
        .freq_valid, .phase_comp, .line_cfg, .reboot_pulse, .reboot_to_loader, .nv_read_only);
    mcsr_host u_host (.clk, .req, .rdata);
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction : rnd
    // values the bank refuses
    function automatic bit ok(input int a, input int v);
        case (a)
            16'h0530: return v >= 1 && v <= 60;
            16'h0600: return v >= 1 && v <= 247;
            16'h052E, 16'h052F: return v != 0;
            16'h0606, 16'h0607, 16'h0609, 16'h060A: return 0;
            default: return 1;
        endcase
    endfunction : ok
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : step
    task automatic w(input int a, input int v);
        u_host.wr(16'(a), 16'(v));
        if (ok(a, v)) mdl[a] = v;
    endtask : w
    task automatic rdc(input int a);
        u_host.xfer(1'b0, 16'(a), 16'h0000, d);
        chk(d, mdl[a]);
    endtask : rdc
    // scaled energy vs clamped quotient
    task automatic en(input logic signed [47:0] r, input int sc);
        longint q;
        w(16'h052E, sc);
        @(posedge clk) energy_raw <= r;
        step(4);
        q = longint'(r) / sc;
        if (q > 64'sd2147483647) q = 64'sd2147483647;
        if (q < -64'sd2147483648) q = -64'sd2147483648;
        chk(48'(energy_int), 48'(q));
    endtask : en
    task automatic end_of_test();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // watchdog, well past the run length
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
    // main sequence
    initial begin
        reset_n = 1'b0;
        query_ok = 1'b0;
        in_loader = 1'b0;
        addr_switch = 4'hF;
        volt_ok = 3'h0;
        energy_raw = '0;
        power_in = '0;
        foreach (ra[i]) mdl[ra[i]] = rv[i];
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        foreach (ra[i]) rdc(ra[i]);
        w(16'h0527, 0);
        foreach (wa[i]) begin
            w(wa[i], wv[i]);
            rdc(wa[i]);
        end
        for (int i = 0; i < 32; i++) w(16'h0540 + i, rnd());
        for (int i = 0; i < 32; i++) rdc(16'h0540 + i);
        en(48'sh0100_0000_0000, 1);
        en(-48'sh0100_0000_0000, 1);
        en({rnd(), rnd(), rnd()}, 1000);
        en(-48'sh0000_0012_3456, 10);
        @(posedge clk) power_in <= {16'h0000, rnd()};
        w(16'h052F, 2);
        w(16'h0530, 3);
        w(16'h0531, 1);
        step(80);
        chk(48'(demand_power), 48'(power_in));
        w(16'h0532, 0);
        w(16'h0533, 2);
        w(16'h0533, 3);
        step(2);
        chk(freq_chan, 2);
        @(posedge clk) volt_ok <= 3'b010;
        w(16'h0532, 1);
        step(4);
        chk(freq_chan, 1);
        chk(freq_valid, 1);
        @(posedge clk) volt_ok <= 3'b000;
        step(4);
        chk(freq_valid, 0);
        w(16'h0526, 16'h0123);
        step(2);
        chk(phase_comp, 16'h0123);
        chk(nv_read_only, 0);
        w(16'h0601, 16'h4B00);
        chk(line_cfg.bit_rate, 16'h2580);
        w(16'h0605, 1);
        step(2);
        chk(line_cfg.bit_rate, 16'h4B00);
        chk(line_cfg.node, 247);
        step(250);
        chk(line_cfg.bit_rate, 16'h2580);
        w(16'h0601, 16'h4B00);
        w(16'h0605, 1);
        @(posedge clk) query_ok <= 1'b1;
        @(posedge clk) query_ok <= 1'b0;
        step(250);
        chk(line_cfg.bit_rate, 16'h4B00);
        @(posedge clk) addr_switch <= 4'h5;
        step(2);
        chk(line_cfg.node, 5);
        w(16'h0609, 16'h1234);
        w(16'h060A, 16'hAA55);
        w(16'h0609, 16'hAA55);
        w(16'h060A, 16'hB001);
        rdc(16'h0609);
        rdc(16'h060A);
        @(posedge clk) in_loader <= 1'b1;
        u_host.xfer(1'b0, 16'h0608, 16'h0000, d);
        chk(d, 2);
        end_of_test();
    end
endmodule : meter_config_system_registers_tb
